/* include/ptr_pkg.sv */
// package for the program memory table-read path
// How it works
// - table address is the high and low pointer registers joined together, except the last-page variant puts the final page in place of the high pointer
// - low byte of the fetched word goes to the operand data register
// - high byte of the fetched word loads the high-byte holder
// - high-byte holder is read-only; software writes never change it
// - every table instruction takes two instruction cycles
// - full-pointer variant fetches at high pointer and low pointer combined
// - programming writes and reads back memory a whole 16-bit word at a time over the parallel progAddr/progWord port
// - debug port is one two-way data line and one input-only clock
// - while debugging on the emulation chip, shared pin functions are blocked
// - debug pins still serve as flash programming data and clock pins
// - program memory is 4K words of 16 bits
`default_nettype none
package ptr_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int HI_W = 4;
    localparam int MEM_DEPTH = 4096;
    localparam int DADDR_W = 8;
    localparam logic [HI_W-1:0] LAST_PAGE = 4'h_F;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h_00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h_0000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        OP_NONE,
        OP_FULL,
        OP_LAST
    } ptr_op_type;

    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } ptr_dwrite_type;

    typedef struct packed {
        logic data;
        logic clk;
    } ptr_pins_type;
endpackage : ptr_pkg
`default_nettype wire

/* hdl/ptr_prog_mem.sv */
// program memory array with synchronous read and a parallel word write port
`default_nettype none
module ptr_prog_mem (
    input wire logic clock,
    input wire logic [ptr_pkg::ADDR_W-1:0] readAddr,
    output logic [ptr_pkg::WORD_W-1:0] readData,
    input wire logic writeEn,
    input wire logic [ptr_pkg::ADDR_W-1:0] writeAddr,
    input wire logic [ptr_pkg::WORD_W-1:0] writeData
);
    logic [ptr_pkg::WORD_W-1:0] memArray [ptr_pkg::MEM_DEPTH];

    always_ff @(posedge clock) begin
        if (writeEn) begin
            memArray[writeAddr] <= writeData;
        end
        readData <= memArray[readAddr];
    end
endmodule : ptr_prog_mem
`default_nettype wire

/* hdl/ptr_table_read.sv */
// table-read engine plus shared programming/debug pin steering
`default_nettype none
module ptr_table_read (
    input wire logic clock,
    input wire logic srst,
    input wire logic instrEn,
    input wire ptr_pkg::ptr_op_type opReq,
    input wire logic [ptr_pkg::DADDR_W-1:0] opDest,
    input wire logic [ptr_pkg::BYTE_W-1:0] lowPtr,
    input wire logic [ptr_pkg::HI_W-1:0] highPtr,
    output logic busy,
    output ptr_pkg::ptr_dwrite_type dataWrite,
    output logic dataWriteValid,
    output logic [ptr_pkg::BYTE_W-1:0] tableHighByteHolder,
    input wire logic progWriteEn,
    input wire logic [ptr_pkg::ADDR_W-1:0] progAddr,
    input wire logic [ptr_pkg::WORD_W-1:0] progWord,
    output logic [ptr_pkg::WORD_W-1:0] progReadWord,
    input wire logic debugMode,
    input wire ptr_pkg::ptr_pins_type pinIn,
    input wire logic pinDataOut,
    input wire logic pinDataOe,
    input wire logic userDataOut,
    input wire logic userDataOe,
    output logic pinDataDrive,
    output logic pinDataEn,
    output ptr_pkg::ptr_pins_type userPinIn,
    output ptr_pkg::ptr_pins_type progPinIn
);
    typedef enum logic {
        ST_IDLE,
        ST_FETCH
    } ptr_state_type;

    function automatic logic [ptr_pkg::ADDR_W-1:0] form_addr(
        input ptr_pkg::ptr_op_type op,
        input logic [ptr_pkg::HI_W-1:0] hi,
        input logic [ptr_pkg::BYTE_W-1:0] lo
    );
        // last page ignores the high pointer entirely
        form_addr = (op == ptr_pkg::OP_LAST) ? {ptr_pkg::LAST_PAGE, lo} : {hi, lo};
    endfunction : form_addr

    // ****************************************
    // fetch sequencer
    // ****************************************
    ptr_state_type state_q, state_d;
    logic [ptr_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [ptr_pkg::DADDR_W-1:0] dest_q, dest_d;
    logic [ptr_pkg::BYTE_W-1:0] high_q, high_d;
    ptr_pkg::ptr_dwrite_type wr_q, wr_d;
    logic wrValid_q, wrValid_d;
    logic [ptr_pkg::WORD_W-1:0] memWord;

    // memory reads addr_d, so the word is ready on the same edge that loads addr_q
    ptr_prog_mem memInst (
        .clock(clock),
        .readAddr(addr_d),
        .readData(memWord),
        .writeEn(progWriteEn),
        .writeAddr(progAddr),
        .writeData(progWord)
    );

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        dest_d = dest_q;
        high_d = high_q;
        wr_d = wr_q;
        wrValid_d = 1'b0;
        if (instrEn) begin
            case (state_q)
                ST_IDLE: begin
                    if (opReq != ptr_pkg::OP_NONE) begin
                        addr_d = form_addr(opReq, highPtr, lowPtr);
                        dest_d = opDest;
                        state_d = ST_FETCH;
                    end else begin
                        // idle address follows the load port so it can read back
                        addr_d = progAddr;
                    end
                end
                ST_FETCH: begin
                    wr_d.addr = dest_q;
                    wr_d.data = memWord[ptr_pkg::BYTE_W-1:0];
                    wrValid_d = 1'b1;
                    high_d = memWord[ptr_pkg::WORD_W-1:ptr_pkg::BYTE_W];
                    state_d = ST_IDLE;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end else if (state_q == ST_IDLE) begin
            addr_d = progAddr;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_IDLE;
            addr_q <= '0;
            dest_q <= '0;
            high_q <= ptr_pkg::BYTE_ZERO;
            wr_q <= '0;
            wrValid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            dest_q <= dest_d;
            high_q <= high_d;
            wr_q <= wr_d;
            wrValid_q <= wrValid_d;
        end
    end

    // holder has no write port at all, only the fetch and reset load it
    assign tableHighByteHolder = high_q;
    assign dataWrite = wr_q;
    assign dataWriteValid = wrValid_q;
    assign busy = (state_q == ST_FETCH);
    assign progReadWord = memWord;

    // ****************************************
    // shared pin steering
    // ****************************************
    // enables pass straight through: high means the pin is driven
    always_comb begin
        if (debugMode) begin
            pinDataDrive = pinDataOut;
            pinDataEn = pinDataOe;
            userPinIn = '0;
        end else begin
            pinDataDrive = userDataOut;
            pinDataEn = userDataOe;
            userPinIn = pinIn;
        end
        progPinIn = pinIn;
    end

    // ****************************************
    // checks
    // ****************************************
    sequence seqStart;
        instrEn && state_q == ST_IDLE && opReq != ptr_pkg::OP_NONE;
    endsequence

    // second slot of a table op: the word is handed over on this edge
    sequence seqFinish;
        busy && instrEn;
    endsequence

    // the low-byte write strobe stands for exactly one clock
    sequence seqPulse;
        dataWriteValid ##1 !dataWriteValid;
    endsequence

    twoCycle_a: assert property (@(posedge clock) disable iff (srst)
        seqStart |=> busy)
        else $error("table instruction did not occupy a second cycle");
    lastPage_a: assert property (@(posedge clock) disable iff (srst)
        instrEn && state_q == ST_IDLE && opReq == ptr_pkg::OP_LAST
        |=> addr_q[ptr_pkg::ADDR_W-1:ptr_pkg::BYTE_W] == ptr_pkg::LAST_PAGE)
        else $error("last page fetch not on final page");
    fullAddr_a: assert property (@(posedge clock) disable iff (srst)
        instrEn && state_q == ST_IDLE && opReq == ptr_pkg::OP_FULL
        |=> addr_q == {$past(highPtr), $past(lowPtr)})
        else $error("full pointer address wrong");
    holdHigh_a: assert property (@(posedge clock) disable iff (srst)
        !$past(busy && instrEn) |-> $stable(tableHighByteHolder))
        else $error("high-byte holder changed outside a fetch");
    debugBlock_a: assert property (@(posedge clock) disable iff (srst)
        debugMode |-> userPinIn == '0)
        else $error("user function saw pins in debug mode");

    // ****************************************
    // hand-over checks
    // ****************************************
    // both halves must come from the word read at the finishing edge
    fetchWord_a: assert property (@(posedge clock) disable iff (srst)
        seqFinish
        |=> {tableHighByteHolder, dataWrite.data} == $past(memWord))
        else $error("fetched word not split into low write and holder");

    validPulse_a: assert property (@(posedge clock) disable iff (srst)
        seqFinish
        |=> seqPulse)
        else $error("low byte write strobe not a single clock");

    // a stray strobe would overwrite an unrelated data register
    strayWrite_a: assert property (@(posedge clock) disable iff (srst)
        !(busy && instrEn)
        |=> !dataWriteValid)
        else $error("low byte write outside a table op");

    // ****************************************
    // timing checks
    // ****************************************
    oneSlot_a: assert property (@(posedge clock) disable iff (srst)
        seqFinish
        |=> !busy)
        else $error("table op ran past its second cycle");

    // between slots the op must stay in flight, not finish early
    waitSlot_a: assert property (@(posedge clock) disable iff (srst)
        busy && !instrEn
        |=> busy)
        else $error("table op ended between instruction slots");

    // ****************************************
    // pin checks
    // ****************************************
    // debug side owns the data pin; the user driver must not leak through
    debugDrive_a: assert property (@(posedge clock) disable iff (srst)
        debugMode
        |-> pinDataDrive == pinDataOut && pinDataEn == pinDataOe)
        else $error("debug driver not on the data pin");

    userDrive_a: assert property (@(posedge clock) disable iff (srst)
        !debugMode
        |-> pinDataDrive == userDataOut && pinDataEn == userDataOe)
        else $error("user driver not on the data pin");
endmodule : ptr_table_read
`default_nettype wire

/* test/ptr_cpu_model.sv */
// cpu core model that issues table reads on instruction slots that come one clock in four
`default_nettype none
module ptr_cpu_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic issue,
    input wire ptr_pkg::ptr_op_type op,
    input wire logic [7:0] dest,
    input wire logic [7:0] lo,
    input wire logic [3:0] hi,
    input wire logic busy,
    output logic instrEn,
    output ptr_pkg::ptr_op_type opReq,
    output logic [7:0] opDest,
    output logic [7:0] lowPtr,
    output logic [3:0] highPtr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q;
    // four clocks make one instruction cycle
    assign instrEn = (phase_q == 2'h3);
    always_ff @(posedge clock) begin
        if (srst) begin
            phase_q <= 2'h0;
            opReq <= ptr_pkg::OP_NONE;
            opDest <= 8'h00;
            lowPtr <= 8'h00;
            highPtr <= 4'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (issue) begin // one read at a time, never nested
                opReq <= op;
                opDest <= dest;
                lowPtr <= lo;
                highPtr <= hi;
            end else if (instrEn && !busy && opReq != ptr_pkg::OP_NONE) begin
                // pointers move on at once: the engine must have latched them
                opReq <= ptr_pkg::OP_NONE;
                lowPtr <= ~lowPtr;
                highPtr <= ~highPtr;
            end
        end
    end
endmodule : ptr_cpu_model
`default_nettype wire

/* test/tb_program_memory_table_read.sv */
// self-checking bench for the table-read engine and pin steering
`default_nettype none
module tb_program_memory_table_read;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic issue = 1'b0;
    ptr_pkg::ptr_op_type op = ptr_pkg::OP_NONE;
    logic [7:0] dest = 8'h00;
    logic [7:0] lo = 8'h00;
    logic [3:0] hi = 4'h0;
    logic instrEn, busy, dataWriteValid, pinDataDrive, pinDataEn;
    ptr_pkg::ptr_op_type opReq;
    logic [7:0] opDest, lowPtr, holder;
    logic [3:0] highPtr;
    ptr_pkg::ptr_dwrite_type dataWrite;
    logic progWriteEn = 1'b0;
    logic [11:0] progAddr = 12'h000;
    logic [15:0] progWord = 16'h0000;
    logic [15:0] progReadWord;
    logic debugMode = 1'b0;
    ptr_pkg::ptr_pins_type pinIn = 2'b00;
    ptr_pkg::ptr_pins_type userPinIn, progPinIn;
    logic pinDataOut = 1'b0;
    logic userDataOut = 1'b0;
    logic pinDataOe = 1'b0;
    logic userDataOe = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    ptr_cpu_model i_cpu (.clock(clock), .srst(srst), .issue(issue), .op(op), .dest(dest),
        .lo(lo), .hi(hi), .busy(busy), .instrEn(instrEn), .opReq(opReq), .opDest(opDest),
        .lowPtr(lowPtr), .highPtr(highPtr));
    ptr_table_read i_dut (.clock(clock), .srst(srst), .instrEn(instrEn), .opReq(opReq),
        .opDest(opDest), .lowPtr(lowPtr), .highPtr(highPtr), .busy(busy),
        .dataWrite(dataWrite), .dataWriteValid(dataWriteValid), .tableHighByteHolder(holder),
        .progWriteEn(progWriteEn), .progAddr(progAddr), .progWord(progWord),
        .progReadWord(progReadWord), .debugMode(debugMode), .pinIn(pinIn),
        .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .userDataOut(userDataOut),
        .userDataOe(userDataOe), .pinDataDrive(pinDataDrive), .pinDataEn(pinDataEn),
        .userPinIn(userPinIn), .progPinIn(progPinIn));
    always #25 clock = ~clock;
    task test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, g);
            n_errors++;
        end
    endtask : chk
    task mem_load(input logic [11:0] a, input logic [15:0] w);
        @(posedge clock);
        progWriteEn <= 1'b1;
        progAddr <= a;
        progWord <= w;
        @(posedge clock);
        progWriteEn <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("readback", w, progReadWord);
    endtask : mem_load
    task tread(input ptr_pkg::ptr_op_type o, input logic [3:0] h, input logic [7:0] l,
            input logic [7:0] d, input logic [15:0] w);
        int n;
        int nb;
        n = 0;
        nb = 0;
        @(posedge clock);
        issue <= 1'b1;
        op <= o;
        hi <= h;
        lo <= l;
        dest <= d;
        @(posedge clock);
        issue <= 1'b0;
        repeat (40) begin
            @(posedge clock);
            if (instrEn === 1'b1) n++;
            if (busy === 1'b1) nb++;
            if (dataWriteValid === 1'b1) break;
        end
        chk("instr cycles", 16'h0002, 16'(n));
        // busy spans one model instruction cycle of four clocks
        chk("busy clocks", 16'h0004, 16'(nb));
        #1 chk("low byte", {8'h00, w[7:0]}, {8'h00, dataWrite.data});
        chk("dest", {8'h00, d}, {8'h00, dataWrite.addr});
        chk("holder", {8'h00, w[15:8]}, {8'h00, holder});
        @(posedge clock);
        #1 chk("valid pulse", 16'h0000, {15'h0000, dataWriteValid});
    endtask : tread
    task pin_check(input logic dm, input logic d);
        @(posedge clock);
        debugMode <= dm;
        pinIn <= {d, ~d};
        pinDataOut <= d;
        userDataOut <= ~d;
        pinDataOe <= d;
        userDataOe <= ~d;
        @(posedge clock);
        #1 chk("prog pins", {14'h0000, pinIn}, {14'h0000, progPinIn});
        chk("user pins", dm ? 16'h0000 : {14'h0000, pinIn}, {14'h0000, userPinIn});
        chk("pin drive", dm ? {14'h0000, d, d} : {14'h0000, ~d, ~d},
            {14'h0000, pinDataDrive, pinDataEn});
    endtask : pin_check
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        mem_load(12'hF06, 16'h001A);
        mem_load(12'hF05, 16'h000F);
        mem_load(12'h3A5, 16'hC35A);
        mem_load(12'hFFF, 16'h8E71);
        tread(ptr_pkg::OP_FULL, 4'hF, 8'h06, 8'h80, 16'h001A);
        tread(ptr_pkg::OP_FULL, 4'hF, 8'h05, 8'h81, 16'h000F);
        tread(ptr_pkg::OP_FULL, 4'h3, 8'hA5, 8'hFF, 16'hC35A);
        tread(ptr_pkg::OP_LAST, 4'h3, 8'hFF, 8'h00, 16'h8E71);
        mem_load(12'hFFF, 16'h0000);
        chk("holder kept", 16'h008E, {8'h00, holder});
        pin_check(1'b0, 1'b1);
        pin_check(1'b1, 1'b0);
        pin_check(1'b1, 1'b1);
        test_done();
    end
endmodule : tb_program_memory_table_read
`default_nettype wire
